// *** verilog/host_bus_map.svh ***
`ifndef HOST_BUS_MAP_SVH
`define HOST_BUS_MAP_SVH
// address field compared against the base register high byte
`define ADDR_W          16
`define DEC_HI          15
`define DEC_LO          4
`define DEC_W           12
// default value of the base register (arbitrary reset value)
`define BASE_RST        12'h030
// wait states the device inserts before ready (sync vl, burst and async)
`define WAIT_CYC        3'h2
`define WAIT_W          3
`define WAIT_ZERO       3'h0
`define WAIT_ONE        3'h1
// host bus clock maximum frequency, mhz
`define HBCLK_MAX_MHZ   50
// host bus clock half period in core clocks, minus one (5 mhz bus clock)
`define HBCLK_W         2
`define HBCLK_LAST      2'h3
`define HBCLK_STEP      2'h1
`define HBCLK_CLR       2'h0
// address strobe low time in core clocks, minus one
`define ADS_W           3
`define ADS_LAST        3'h3
`define ADS_STEP        3'h1
`define ADS_CLR         3'h0
`endif

// *** verilog/host_bus_pkg.sv ***
package host_bus_pkg;
  // bus operating mode taken from the mode strap
  typedef enum logic [1:0] {
    mode_sync_vl,
    mode_burst,
    mode_async
  } bus_mode_t;
  // access sequencing of the device end
  typedef enum logic [1:0] {
    st_idle,
    st_wait,
    st_ready
  } acc_state_t;
endpackage

// *** verilog/host_bus_if.sv ***
`timescale 1ns/1ps
`include "host_bus_map.svh"
interface host_bus_if;
  logic                 data_port_select_n;     // direct data register select
  logic                 address_qualifier_n;    // address enable, active low
  logic                 address_latch_strobe_n; // address latch strobe
  logic [`ADDR_W-1:0]   addr;                   // address lines
  logic                 read_strobe_n;          // async read strobe
  logic                 write_strobe_n;         // async write strobe
  logic                 command_cycle_n;        // command cycle / burst dir
  logic                 sync_write_read;        // sync direction, high=write
  logic                 host_bus_clock;         // host bus clock level
  logic                 sync_ready_n;           // sync ready, active low
  logic                 sync_ready_oe;          // sync ready driven
  logic                 async_ready;            // async ready
  logic                 async_ready_oe;         // async ready driven
  logic                 irq_n;                  // interrupt, active low
  logic                 local_device_match_n;   // address match, active low
  modport device (
    input  data_port_select_n, address_qualifier_n, address_latch_strobe_n,
    input  addr, read_strobe_n, write_strobe_n, command_cycle_n,
    input  sync_write_read, host_bus_clock,
    output sync_ready_n, sync_ready_oe, async_ready, async_ready_oe,
    output irq_n, local_device_match_n
  );
  modport host (
    output data_port_select_n, address_qualifier_n, address_latch_strobe_n,
    output addr, read_strobe_n, write_strobe_n, command_cycle_n,
    output sync_write_read, host_bus_clock,
    input  sync_ready_n, sync_ready_oe, async_ready, async_ready_oe,
    input  irq_n, local_device_match_n
  );
endinterface

// *** verilog/host_bus_device.sv ***
`timescale 1ns/1ps
`include "host_bus_map.svh"
module host_bus_device
  import host_bus_pkg::*;
(
  input  wire logic             mclk,             // core clock 40 mhz
  input  wire logic             reset_n,          // async reset
  input  wire logic             clk_en,           // freezes state when low
  host_bus_if.device            bus,              // host bus pins
  input  wire logic             bus_mode_select_n,// mode strap pin
  input  wire logic             burst_strap,      // strap high: burst not async
  input  wire logic [7:0]       base_addr_hi,     // base register high byte
  input  wire logic [`DEC_W-1:0] base_addr_lo_nib,// unused low part kept zero
  input  wire logic             irq_status_any,   // any status bit set
  output host_bus_pkg::bus_mode_t mode,           // captured bus mode
  output logic                  data_sel,         // queue data pair selected
  output logic                  reg_sel,          // register window selected
  output logic                  access_wr,        // access is a write
  output logic [`ADDR_W-1:0]    latched_addr      // latched address
);
  import host_bus_pkg::*;

  // three-stage samplers for pins from outside the mclk domain
  logic [2:0] clk_sync_ff;                        // host bus clock sampler
  logic [2:0] rd_sync_ff;                         // read strobe sampler
  logic [2:0] wr_sync_ff;                         // write strobe sampler
  logic [2:0] ads_sync_ff;                        // latch strobe sampler
  logic [2:0] sel_sync_ff;                        // selection sampler
  logic       clk_lvl_ff;                         // agreed clock level
  logic       rd_lvl_ff;                          // agreed read level
  logic       wr_lvl_ff;                          // agreed write level
  logic       ads_lvl_ff;                         // agreed latch level
  logic       sel_lvl_ff;                         // agreed select level
  logic       strap_done_ff;                      // strap captured once
  bus_mode_t  mode_ff;                            // mode register
  acc_state_t state_ff;                           // access state
  acc_state_t nxt_state;                          // next access state
  logic [`WAIT_W-1:0] wait_ff;                    // wait counter
  logic [`WAIT_W-1:0] nxt_wait;                   // next wait count
  logic       srdy_ff;                            // sync ready, active low
  logic       async_ready_ff;                            // async ready
  logic [`ADDR_W-1:0] addr_ff;                    // latched address
  logic       aq_lat_ff;                          // latched qualifier
  logic       wr_ff;                              // direction register
  logic       reg_sel_ff;                         // register window select

  // agreement of stages two and three marks a settled change
  function automatic logic settle(input logic [2:0] s, input logic old);
    settle = (s[2] == s[1]) ? s[1] : old;
  endfunction

  // address decode shared by live and latched paths
  function automatic logic decode_hit(input logic [`ADDR_W-1:0] a,
                                      input logic q,
                                      input logic [7:0] hi);
    decode_hit = !q && (a[`DEC_HI:`DEC_LO] == {hi, 4'h0});
  endfunction

  // selection wires
  wire live_hit   = decode_hit(bus.addr, bus.address_qualifier_n,
                               base_addr_hi);
  wire selected   = !bus.data_port_select_n || live_hit;
  wire clk_rise   = (clk_sync_ff[2] == clk_sync_ff[1]) && clk_sync_ff[1]
                    && !clk_lvl_ff;
  wire strobe_on  = (mode_ff == mode_async) ? (!rd_lvl_ff || !wr_lvl_ff)
                    : clk_rise;
  wire ads_rise   = settle(ads_sync_ff, ads_lvl_ff) && !ads_lvl_ff;

  // match is a plain gate of pins, no flip-flop
  assign bus.local_device_match_n = !live_hit;
  // interrupt follows any status bit
  assign bus.irq_n          = !irq_status_any;
  // ready pins only driven while this device is selected
  assign bus.sync_ready_n   = srdy_ff;
  assign bus.sync_ready_oe  = selected && (mode_ff != mode_async);
  assign bus.async_ready    = async_ready_ff;
  assign bus.async_ready_oe = selected && (mode_ff == mode_async);
  assign mode         = mode_ff;
  assign data_sel     = !bus.data_port_select_n;
  assign reg_sel      = reg_sel_ff;
  assign access_wr    = wr_ff;
  assign latched_addr = addr_ff;

  // input samplers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_sync_ff <= 3'h0;
      rd_sync_ff  <= 3'h7;
      wr_sync_ff  <= 3'h7;
      ads_sync_ff <= 3'h7;
      sel_sync_ff <= 3'h0;
    end
    else if (clk_en)
    begin
      clk_sync_ff <= {clk_sync_ff[1:0], bus.host_bus_clock};
      rd_sync_ff  <= {rd_sync_ff[1:0], bus.read_strobe_n};
      wr_sync_ff  <= {wr_sync_ff[1:0], bus.write_strobe_n};
      ads_sync_ff <= {ads_sync_ff[1:0], bus.address_latch_strobe_n};
      sel_sync_ff <= {sel_sync_ff[1:0], selected};
    end
  end

  // settled levels
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_lvl_ff <= 1'b0;
      rd_lvl_ff  <= 1'b1;
      wr_lvl_ff  <= 1'b1;
      ads_lvl_ff <= 1'b1;
      sel_lvl_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      clk_lvl_ff <= settle(clk_sync_ff, clk_lvl_ff);
      rd_lvl_ff  <= settle(rd_sync_ff, rd_lvl_ff);
      wr_lvl_ff  <= settle(wr_sync_ff, wr_lvl_ff);
      ads_lvl_ff <= settle(ads_sync_ff, ads_lvl_ff);
      sel_lvl_ff <= settle(sel_sync_ff, sel_lvl_ff);
    end
  end

  // mode strap caught once after reset release
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_done_ff <= 1'b0;
      mode_ff       <= mode_sync_vl;
    end
    else if (clk_en && !strap_done_ff)
    begin
      strap_done_ff <= 1'b1;
      if (!bus_mode_select_n)
        mode_ff <= mode_sync_vl;
      else if (burst_strap)
        mode_ff <= mode_burst;
      else
        mode_ff <= mode_async;
    end
  end

  // address latch on the rising strobe edge
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_ff    <= 16'h0000;
      aq_lat_ff  <= 1'b1;
      reg_sel_ff <= 1'b0;
    end
    else if (clk_en && ads_rise)
    begin
      addr_ff    <= {bus.addr[`ADDR_W-1:1], 1'b0};
      aq_lat_ff  <= bus.address_qualifier_n;
      reg_sel_ff <= decode_hit(bus.addr, bus.address_qualifier_n,
                               base_addr_hi);
    end
  end

  // access sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    case (state_ff)
      st_idle:
        if (sel_lvl_ff && strobe_on)
        begin
          nxt_state = st_wait;
          nxt_wait  = `WAIT_CYC;
        end
      st_wait:
        if (!sel_lvl_ff)
          nxt_state = st_idle;
        else if (strobe_on || mode_ff == mode_async)
        begin
          if (wait_ff == `WAIT_ONE || wait_ff == `WAIT_ZERO)
            nxt_state = st_ready;
          else
            nxt_wait = wait_ff - `WAIT_ONE;
        end
      st_ready:
        if (mode_ff == mode_async ? (rd_lvl_ff && wr_lvl_ff) : clk_rise)
          nxt_state = st_idle;
      default:
        nxt_state = st_idle;
    endcase
  end

  // state, direction and ready registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= st_idle;
      wait_ff  <= `WAIT_ZERO;
      srdy_ff  <= 1'b1;
      async_ready_ff  <= 1'b1;
      wr_ff    <= 1'b0;
    end
    else if (clk_en)
    begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
      if (state_ff == st_idle && nxt_state == st_wait)
        wr_ff <= (mode_ff == mode_async) ? !wr_lvl_ff
               : (mode_ff == mode_burst) ? !bus.command_cycle_n
               : bus.sync_write_read;
      if (mode_ff == mode_burst)
        srdy_ff <= !(nxt_state == st_wait);
      else if (mode_ff == mode_sync_vl)
        srdy_ff <= !(nxt_state == st_ready);
      else
        srdy_ff <= 1'b1;
      async_ready_ff <= !((mode_ff == mode_async) && nxt_state == st_wait);
    end
  end
endmodule // host_bus_device

// *** verilog/host_bus_host.sv ***
`timescale 1ns/1ps
`include "host_bus_map.svh"
// host end: drives a single access per request, clock from a divider
module host_bus_host
  import host_bus_pkg::*;
(
  input  wire logic             mclk,        // core clock
  input  wire logic             reset_n,     // async reset
  input  wire logic             clk_en,      // freezes state when low
  host_bus_if.host              bus,         // host bus pins
  input  wire host_bus_pkg::bus_mode_t mode, // mode of the link
  input  wire logic             req,         // start an access
  input  wire logic             req_wr,      // write when high
  input  wire logic             req_data,    // use data port select
  input  wire logic [`ADDR_W-1:0] req_addr,  // access address
  output logic                  busy,        // access in progress
  output logic                  done,        // access finished pulse
  output logic                  irq_seen     // device interrupt level
);
  import host_bus_pkg::*;

  logic                 clk_ff;     // divided bus clock, 5 mhz
  logic [`HBCLK_W-1:0]  div_ff;     // bus clock half period counter
  logic                 act_ff;     // access active
  logic                 wr_ff;      // direction
  logic                 dsel_ff;    // data port select
  logic [`ADDR_W-1:0]   addr_ff;    // address
  logic                 done_ff;    // finish pulse
  logic                 ads_ff;     // latch strobe
  logic [`ADS_W-1:0]    ads_cnt_ff; // latch strobe low time
  logic [2:0]           ry_ff;      // ready sampler
  logic                 armed_ff;   // ready pin seen at its arming level: high in vl, low in burst and async

  // a slow bus clock so that the device's three-flop sampler can follow it
  wire sync_mode = (mode != mode_async);
  wire vl_mode   = (mode == mode_sync_vl);
  wire ry_agreed = (ry_ff[2] == ry_ff[1]);
  wire ry_low    = ry_agreed && !ry_ff[1];
  wire ry_high   = ry_agreed && ry_ff[1];
  // vl: ready is a fall after a high, so a stale low is never taken
  // burst and async: the access ends when a low wait indication ends
  wire arm_now   = vl_mode ? ry_high : ry_low;
  wire end_now   = vl_mode ? ry_low : ry_high;
  wire take_req  = req && !act_ff;
  wire finish    = act_ff && armed_ff && end_now;

  assign bus.host_bus_clock         = clk_ff;
  assign bus.data_port_select_n     = !(act_ff && dsel_ff);
  assign bus.address_qualifier_n    = !(act_ff && !dsel_ff);
  assign bus.address_latch_strobe_n = ads_ff;
  assign bus.addr                   = addr_ff;
  assign bus.read_strobe_n  = !(act_ff && !sync_mode && !wr_ff);
  assign bus.write_strobe_n = !(act_ff && !sync_mode && wr_ff);
  assign bus.command_cycle_n = (mode == mode_burst) ? !wr_ff
                             : !act_ff;
  assign bus.sync_write_read = wr_ff;
  assign busy     = act_ff;
  assign done     = done_ff;
  assign irq_seen = !bus.irq_n;

  // access control and divided clock
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_ff  <= 1'b0;
      act_ff  <= 1'b0;
      wr_ff   <= 1'b0;
      dsel_ff <= 1'b0;
      addr_ff <= 16'h0000;
      done_ff <= 1'b0;
      ads_ff  <= 1'b1;
      ry_ff   <= 3'h7;
      div_ff     <= `HBCLK_CLR;
      ads_cnt_ff <= `ADS_CLR;
      armed_ff   <= 1'b0;
    end
    else if (clk_en)
    begin
      // bus clock toggles once per half period
      div_ff  <= (div_ff == `HBCLK_LAST) ? `HBCLK_CLR : div_ff + `HBCLK_STEP;
      if (div_ff == `HBCLK_LAST)
        clk_ff <= !clk_ff;
      ry_ff   <= {ry_ff[1:0], sync_mode ? bus.sync_ready_n : bus.async_ready};
      done_ff <= finish;
      if (take_req)
      begin
        act_ff     <= 1'b1;
        armed_ff   <= 1'b0;
        ads_ff     <= 1'b0;
        ads_cnt_ff <= `ADS_CLR;
        wr_ff      <= req_wr;
        dsel_ff    <= req_data;
        addr_ff    <= req_addr;
      end
      else
      begin
        if (finish)
          act_ff <= 1'b0;
        if (act_ff && arm_now)
          armed_ff <= 1'b1;
        // strobe held low long enough for the device sampler
        if (!ads_ff)
          ads_cnt_ff <= ads_cnt_ff + `ADS_STEP;
        if (!ads_ff && ads_cnt_ff == `ADS_LAST)
          ads_ff <= 1'b1;
      end
    end
  end
endmodule // host_bus_host

// *** sim/host_bus_port_assertions.sv ***
`timescale 1ns/1ps
`include "host_bus_map.svh"
// watches the joined host bus pins beside the device's mode and select
module host_bus_port_assertions
(
  input wire logic                    mclk,                 // core clock
  input wire logic                    reset_n,              // async reset
  input wire logic                    data_port_select_n,   // data select
  input wire logic                    address_qualifier_n,  // address enable
  input wire logic [`ADDR_W-1:0]      addr,                 // address lines
  input wire logic                    read_strobe_n,        // async read
  input wire logic                    write_strobe_n,       // async write
  input wire logic                    sync_ready_n,         // sync ready
  input wire logic                    sync_ready_oe,        // sync ready on
  input wire logic                    async_ready,          // async ready
  input wire logic                    async_ready_oe,       // async ready on
  input wire logic                    irq_n,                // interrupt
  input wire logic                    local_device_match_n, // address match
  input wire logic [7:0]              base_addr_hi,         // base high byte
  input wire logic                    irq_status_any,       // status level
  input wire logic                    bus_mode_select_n,    // mode strap
  input wire logic                    burst_strap,          // burst pick
  input wire host_bus_pkg::bus_mode_t mode,                 // captured mode
  input wire logic                    data_sel              // data selected
);
  import host_bus_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // decode expected from the qualifier and the upper address bits
  wire hit  = !address_qualifier_n
              && addr[`DEC_HI:`DEC_LO] == {base_addr_hi, 4'h0};
  wire idle = data_port_select_n && local_device_match_n; // nobody selects
  chk_match_decode: assert property (
    local_device_match_n == !hit)
    else $error("address match output wrong");
  chk_irq_level: assert property (irq_n == !irq_status_any)
    else $error("interrupt output wrong");
  chk_data_select: assert property (
    data_sel == !data_port_select_n)
    else $error("data port select not honoured");
  chk_sync_strap: assert property (
    !bus_mode_select_n && $past(reset_n) |-> mode == mode_sync_vl)
    else $error("strap low not synchronous");
  chk_async_strap: assert property (
    bus_mode_select_n && $past(reset_n)
    |-> mode == (burst_strap ? mode_burst : mode_async))
    else $error("strap high mode wrong");
  chk_async_quiet: assert property (
    mode == mode_async |-> sync_ready_n)
    else $error("sync ready moved in async mode");
  chk_vl_ready_sel: assert property (
    mode == mode_sync_vl && $fell(sync_ready_n) |-> sync_ready_oe && !idle)
    else $error("vl ready fell while not selected");
  chk_burst_wait_end: assert property (
    mode == mode_burst && $fell(sync_ready_n)
    |-> ##[1:200] $rose(sync_ready_n))
    else $error("burst wait state never ended");
  chk_async_extend: assert property (
    $fell(async_ready) |-> !read_strobe_n || !write_strobe_n)
    else $error("async ready lowered without a strobe");
  chk_ready_unsel: assert property (
    idle [*8] |-> !sync_ready_oe && !async_ready_oe
    && sync_ready_n && async_ready)
    else $error("ready driven while unselected");
  // main scenarios reached
  cov_vl_ready: cover property (mode == mode_sync_vl && $fell(sync_ready_n));
  cov_burst_wait: cover property (mode == mode_burst && $fell(sync_ready_n));
  cov_async_wait: cover property ($fell(async_ready));
  cov_data_port: cover property (data_sel && address_qualifier_n);
endmodule // host_bus_port_assertions

// *** sim/host_local_bus_port_test.sv ***
`timescale 1ns/1ps
`include "host_bus_map.svh"
// joins host and device ends, runs each strap mode against a queue model
module host_local_bus_port_test;
  import host_bus_pkg::*;
  logic               mclk = 0;       // 40 mhz core clock
  logic               reset_n = 0;    // async reset, active low
  logic               bms_n = 0;      // mode strap
  logic               burst = 0;      // burst pick under strap high
  logic               irq_any = 0;    // interrupt status level
  logic               req = 0;        // host request
  logic               req_wr = 0;     // request is a write
  logic               req_data = 0;   // request uses data port select
  logic [7:0]         base = 8'h03;   // base register high byte
  logic [`ADDR_W-1:0] req_addr = '0;  // request address
  bus_mode_t          mode;           // captured mode
  logic               data_sel, reg_sel, access_wr, busy, done, irq_seen;
  logic [`ADDR_W-1:0] latched_addr;   // device latched address
  logic [`ADDR_W:0]   exp_q[$];       // model queue of {wr, addr}
  int                 errors = 0;
  int                 comparisons = 0;
  int                 seed = 32'h0B1805FE;
  host_bus_if bus_if ();
  // free running clock
  always #12.5 mclk = ~mclk;
  host_bus_device host_bus_device_inst (.mclk(mclk), .reset_n(reset_n),
    .clk_en(1'b1), .bus(bus_if), .bus_mode_select_n(bms_n),
    .burst_strap(burst), .base_addr_hi(base), .base_addr_lo_nib('0),
    .irq_status_any(irq_any), .mode(mode), .data_sel(data_sel),
    .reg_sel(reg_sel), .access_wr(access_wr), .latched_addr(latched_addr));
  host_bus_host host_bus_host_inst (.mclk(mclk), .reset_n(reset_n),
    .clk_en(1'b1), .bus(bus_if), .mode(mode), .req(req), .req_wr(req_wr),
    .req_data(req_data), .req_addr(req_addr), .busy(busy), .done(done),
    .irq_seen(irq_seen));
  host_bus_port_assertions host_bus_port_assertions_inst (.mclk(mclk),
    .reset_n(reset_n), .data_port_select_n(bus_if.data_port_select_n),
    .address_qualifier_n(bus_if.address_qualifier_n), .addr(bus_if.addr),
    .read_strobe_n(bus_if.read_strobe_n),
    .write_strobe_n(bus_if.write_strobe_n),
    .sync_ready_n(bus_if.sync_ready_n), .sync_ready_oe(bus_if.sync_ready_oe),
    .async_ready(bus_if.async_ready), .async_ready_oe(bus_if.async_ready_oe),
    .irq_n(bus_if.irq_n), .local_device_match_n(bus_if.local_device_match_n),
    .base_addr_hi(base), .irq_status_any(irq_any),
    .bus_mode_select_n(bms_n), .burst_strap(burst), .mode(mode),
    .data_sel(data_sel));
  // compares one value, counts and reports
  task check_val(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // prints counts and verdict, ends the run
  task give_verdict();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one access: data port hits an unmatched address, else a matched one
  task access(input logic wr, input logic dat);
    logic [`ADDR_W-1:0] a;
    logic [`ADDR_W:0]   e;
    int                 n;
    a = dat ? {~base, 8'($random(seed))} : {base, 4'h0, 4'($random(seed))};
    @(negedge mclk);
    req <= 1'b1;
    req_wr <= wr;
    req_data <= dat;
    req_addr <= a;
    irq_any <= 1'($random(seed));
    exp_q.push_back({wr, a});
    @(negedge mclk);
    req <= 1'b0;
    @(negedge mclk);
    check_val(bus_if.local_device_match_n, dat);
    check_val(data_sel, dat);
    check_val(busy, 1'b1);
    check_val(bus_if.command_cycle_n, (bms_n && burst) ? !wr : 1'b0);
    check_val(bus_if.sync_write_read, wr);
    check_val({bus_if.read_strobe_n, bus_if.write_strobe_n},
      (bms_n && !burst) ? {wr, !wr} : 2'h3);
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    check_val(n < 300, 1);
    e = exp_q.pop_front();
    check_val(access_wr, e[`ADDR_W]);
    check_val(reg_sel, !dat);
    if (!dat) check_val(latched_addr, {e[`ADDR_W-1:1], 1'b0});
    check_val(irq_seen, irq_any);
    check_val(bus_if.irq_n, !irq_any);
    // let the device settle back to idle before the next request
    repeat (8) @(negedge mclk);
  endtask
  // each strap setting in turn: sync vl, burst, async
  initial
  begin
    for (int m = 0; m < 3; m++)
    begin
      reset_n <= 1'b0;
      bms_n <= (m != 0);
      burst <= (m == 1);
      base <= 8'($random(seed));
      repeat (2) @(negedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(negedge mclk);
      check_val(mode, !bms_n ? mode_sync_vl
        : (burst ? mode_burst : mode_async));
      for (int k = 0; k < 8; k++)
        access(1'($random(seed)), k[0]);
    end
    give_verdict();
  end
  // cuts a hang short
  initial
  begin
    #(25 * 20000);
    errors++;
    give_verdict();
  end
endmodule // host_local_bus_port_test
